/* File: design/ocfs_defines.svh */
// Register map, field positions, reset values and frequency constants.
// Assumes a 32-bit AHB-Lite register bus; frequencies are held in kHz.
`ifndef OCFS_DEFINES_SVH
`define OCFS_DEFINES_SVH
// Byte offsets
`define OCFS_OFF_MAIN_CTRL 32'h00000000
`define OCFS_OFF_AUX_CTRL 32'h00000004
`define OCFS_OFF_MCTRL_SIX 32'h00000008
`define OCFS_OFF_MCTRL_SEVEN 32'h0000000C
`define OCFS_OFF_OUT_ONE 32'h00000010
`define OCFS_OFF_OUT_TWO 32'h00000014
`define OCFS_OFF_OUT_THREE 32'h00000018
`define OCFS_OFF_OUT_FOUR 32'h0000001C
`define OCFS_OFF_OUT_FIVE 32'h00000020
`define OCFS_OFF_STATUS 32'h00000024
// Register indices
`define OCFS_IDX_MAIN 4'h0
`define OCFS_IDX_AUX 4'h1
`define OCFS_IDX_SIX 4'h2
`define OCFS_IDX_SEVEN 4'h3
`define OCFS_IDX_OUT1 4'h4
`define OCFS_IDX_OUT2 4'h5
`define OCFS_IDX_OUT3 4'h6
`define OCFS_IDX_OUT4 4'h7
`define OCFS_IDX_OUT5 4'h8
`define OCFS_IDX_STAT 4'h9
`define OCFS_IDX_NONE 4'hF
// Fields
`define OCFS_MAIN_FREQ 2:0
`define OCFS_M2A_FREQ 6:4
`define OCFS_LOCK_BIT 7
`define OCFS_S1_FAM_BIT 0
`define OCFS_S2_FAM_BIT 1
`define OCFS_S2_ALT_BIT 2
`define OCFS_S1_MULT 1:0
`define OCFS_S2_MULT 3:2
`define OCFS_LO_NIB 3:0
`define OCFS_HI_NIB 7:4
`define OCFS_ST_AUX_UP 0
`define OCFS_ST_LOCK 1
`define OCFS_ST_EN 14:8
`define OCFS_HTRANS_ACT 1
`define OCFS_RST_VAL 8'h00
`define OCFS_NOUT 7
// Frequencies in kHz
`define OCFS_K311040 19'h4BF00
`define OCFS_K98304 19'h18000
`define OCFS_K131072 19'h20000
`define OCFS_K148224 19'h24300
`define OCFS_K98816 19'h18200
`define OCFS_K100992 19'h18A80
`define OCFS_K250000 19'h3D090
`define OCFS_K274944 19'h43200
`define OCFS_K178944 19'h2BB00
`define OCFS_K122880 19'h1E000
`define OCFS_K160000 19'h27100
`define OCFS_K104000 19'h19640
`define OCFS_K312500 19'h4C4B4
`define OCFS_K_E1 19'h00800
`define OCFS_K_DS1 19'h00608
`define OCFS_K6312 19'h018A8
`define OCFS_K10000 19'h02710
`define OCFS_K19440 19'h04BF0
`define OCFS_K38880 19'h097E0
`define OCFS_K_NONE 19'h00000
`endif

/* File: design/ocfs_pkg.sv */
// Types shared by the output clock frequency select block.
// Assumes ocfs_defines.svh supplies the numeric constants.
package ocfs_pkg;
	typedef enum logic [3:0] {
		OCFS_SRC_OFF = 4'h0,
		OCFS_SRC_2K = 4'h1,
		OCFS_SRC_8K = 4'h2,
		OCFS_SRC_SYN1 = 4'h3,
		OCFS_SRC_SYN2 = 4'h4,
		OCFS_SRC_MAIN = 4'h5,
		OCFS_SRC_SECOND = 4'h6,
		OCFS_SRC_AUX = 4'h7,
		OCFS_SRC_AUXREF = 4'h8
	} ocfs_src_t;
endpackage : ocfs_pkg

/* File: design/ocfs_apll_decode.sv */
// Decodes APLL and synthesizer frequency fields into kHz values.
// Assumes fields come straight from registers; purely combinational.
`timescale 1ns/1ps
`include "ocfs_defines.svh"
module ocfs_apll_decode (
	input wire logic lock_sel_in,
	input wire logic [2:0] main_freq_in,
	input wire logic [2:0] main_to_aux_in,
	input wire logic [3:0] aux_freq_in,
	input wire logic syn1_fam_in,
	input wire logic [1:0] syn1_mult_in,
	input wire logic syn2_fam_in,
	input wire logic syn2_alt_in,
	input wire logic [1:0] syn2_mult_in,
	output logic [18:0] main_khz_out,
	output logic [18:0] aux_khz_out,
	output logic [18:0] syn1_khz_out,
	output logic [18:0] syn2_khz_out,
	output logic aux_up_out
);
	always_comb begin
		unique case (main_freq_in)
			3'h2: main_khz_out = `OCFS_K98304;
			3'h3: main_khz_out = `OCFS_K131072;
			3'h4: main_khz_out = `OCFS_K148224;
			3'h5: main_khz_out = `OCFS_K98816;
			3'h6: main_khz_out = `OCFS_K100992;
			3'h7: main_khz_out = `OCFS_K250000;
			default: main_khz_out = `OCFS_K311040;
		endcase
		aux_khz_out = `OCFS_K_NONE;
		if (lock_sel_in) begin
			case (main_to_aux_in)
				3'h0: aux_khz_out = `OCFS_K98304;
				3'h1: aux_khz_out = `OCFS_K250000;
				3'h2: aux_khz_out = `OCFS_K131072;
				3'h4: aux_khz_out = `OCFS_K148224;
				3'h6: aux_khz_out = `OCFS_K98816;
				3'h7: aux_khz_out = `OCFS_K100992;
				default: aux_khz_out = `OCFS_K_NONE;
			endcase
		end else begin
			case (aux_freq_in)
				4'h1: aux_khz_out = `OCFS_K311040;
				4'h2: aux_khz_out = `OCFS_K98304;
				4'h3: aux_khz_out = `OCFS_K131072;
				4'h4: aux_khz_out = `OCFS_K148224;
				4'h5: aux_khz_out = `OCFS_K98816;
				4'h6: aux_khz_out = `OCFS_K274944;
				4'h7: aux_khz_out = `OCFS_K178944;
				4'h8: aux_khz_out = `OCFS_K100992;
				4'h9: aux_khz_out = `OCFS_K250000;
				4'hA: aux_khz_out = `OCFS_K122880;
				4'hB: aux_khz_out = `OCFS_K160000;
				4'hC: aux_khz_out = `OCFS_K104000;
				default: aux_khz_out = `OCFS_K_NONE;
			endcase
		end
		aux_up_out = lock_sel_in | (aux_freq_in != 4'h0);
		syn1_khz_out = (syn1_fam_in ? `OCFS_K_DS1 : `OCFS_K_E1) << syn1_mult_in;
		syn2_khz_out = (syn2_fam_in ? `OCFS_K_DS1 : `OCFS_K_E1) << syn2_mult_in;
		if (syn2_alt_in) begin
			case ({syn2_mult_in, syn2_fam_in})
				3'h0: syn2_khz_out = `OCFS_K6312;
				3'h4: syn2_khz_out = `OCFS_K10000;
				3'h1: syn2_khz_out = `OCFS_K19440;
				3'h3: syn2_khz_out = `OCFS_K38880;
				default: syn2_khz_out = `OCFS_K_NONE;
			endcase
		end
	end
endmodule : ocfs_apll_decode

/* File: design/ocfs_out_slot.sv */
// One output clock: maps its selection code to a source and divider.
// Assumes edge_in pulses for one cycle at each output clock boundary.
`timescale 1ns/1ps
`include "ocfs_defines.svh"
module ocfs_out_slot #(
	parameter int IDX = 0
) (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic [3:0] sel_in,
	input wire logic alt_in,
	input wire logic edge_in,
	input wire logic aux_up_in,
	output logic en_out,
	output ocfs_pkg::ocfs_src_t src_out,
	output logic [6:0] div_out
);
	import ocfs_pkg::*;
	ocfs_src_t src_reg, src_next;
	logic [3:0] m_src;
	logic [6:0] div_reg, div_next, m_div;
	logic en_reg, en_next;
	localparam int GRP = (IDX < 3) ? 0 : ((IDX < 5) ? 1 : 2);

	always_comb begin
		m_src = OCFS_SRC_OFF;
		m_div = 7'h01;
		if (!alt_in) begin
			unique case (sel_in)
				4'h1: m_src = OCFS_SRC_2K;
				4'h2: m_src = OCFS_SRC_8K;
				4'h3: begin
					m_src = (IDX == 5) ? OCFS_SRC_MAIN : OCFS_SRC_SYN2;
					m_div = (IDX == 5) ? 7'h02 : 7'h01;
				end
				4'h4: begin
					m_src = (IDX == 6) ? OCFS_SRC_MAIN : OCFS_SRC_SYN1;
					m_div = (IDX == 6) ? 7'h02 : 7'h01;
				end
				4'h5: begin
					m_src = OCFS_SRC_MAIN;
					m_div = (IDX == 5) ? 7'h01 : 7'h30;
				end
				4'h6: {m_src, m_div} = {OCFS_SRC_MAIN, 7'h10};
				4'h7: {m_src, m_div} = {OCFS_SRC_MAIN, 7'h0C};
				4'h8: {m_src, m_div} = {OCFS_SRC_MAIN, 7'h08};
				4'h9: {m_src, m_div} = {OCFS_SRC_MAIN, 7'h06};
				4'hA: {m_src, m_div} = {OCFS_SRC_MAIN, 7'h04};
				4'hB: begin
					m_src = OCFS_SRC_AUX;
					m_div = (GRP == 1) ? 7'h02 : 7'h40;
				end
				4'hC: {m_src, m_div} = {OCFS_SRC_AUX, 7'h30};
				4'hD: {m_src, m_div} = {OCFS_SRC_AUX, 7'h10};
				4'hE: {m_src, m_div} = {OCFS_SRC_AUX, 7'h08};
				4'hF: {m_src, m_div} = {OCFS_SRC_AUX, 7'h04};
				default: m_src = OCFS_SRC_OFF;
			endcase
		end else begin
			unique case (sel_in)
				4'h1: {m_src, m_div} = (GRP == 0) ? {OCFS_SRC_MAIN, 7'h40} :
					(GRP == 1) ? {OCFS_SRC_MAIN, 7'h02} : {OCFS_SRC_AUX, 7'h05};
				4'h2: {m_src, m_div} = (GRP == 0) ? {OCFS_SRC_AUX, 7'h14} :
					(GRP == 1) ? {OCFS_SRC_MAIN, 7'h01} : {OCFS_SRC_AUX, 7'h02};
				4'h3: {m_src, m_div} = (GRP == 0) ? {OCFS_SRC_AUX, 7'h0C} :
					(GRP == 1) ? {OCFS_SRC_AUX, 7'h0A} : {OCFS_SRC_AUX, 7'h01};
				4'h4: {m_src, m_div} = (GRP == 0) ? {OCFS_SRC_AUX, 7'h0A} :
					(GRP == 1) ? {OCFS_SRC_SECOND, 7'h0A} : {OCFS_SRC_SECOND, 7'h05};
				4'h5: {m_src, m_div} = (IDX == 0) ? {OCFS_SRC_SECOND, 7'h0A} :
					(GRP == 0) ? {OCFS_SRC_AUX, 7'h05} : {OCFS_SRC_SECOND, 7'h02};
				4'h6: {m_src, m_div} = (IDX == 0) ? {OCFS_SRC_SECOND, 7'h05} :
					(GRP == 0) ? {OCFS_SRC_AUX, 7'h02} : {OCFS_SRC_SECOND, 7'h01};
				4'h7: m_src = OCFS_SRC_AUXREF;
				default: m_src = OCFS_SRC_OFF;
			endcase
		end
		src_next = src_reg;
		div_next = div_reg;
		if (edge_in || !en_reg) begin
			src_next = ocfs_src_t'(m_src);
			div_next = m_div;
		end
		en_next = (src_next != OCFS_SRC_OFF) &&
			!((src_next == OCFS_SRC_AUX) && !aux_up_in);
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			src_reg <= OCFS_SRC_OFF;
			div_reg <= 7'h01;
			en_reg <= 1'b0;
		end else begin
			src_reg <= src_next;
			div_reg <= div_next;
			en_reg <= en_next;
		end
	end

	assign en_out = en_reg;
	assign src_out = src_reg;
	assign div_out = div_reg;
endmodule : ocfs_out_slot

/* File: design/ocfs_top.sv */
// Output clock frequency select: AHB-Lite registers, APLL decode, seven outputs.
// Assumes a single 20 MHz clock and one-cycle output boundary pulses.
`timescale 1ns/1ps
`include "ocfs_defines.svh"
module ocfs_top (
	input wire logic core_clk_in,
	input wire logic rstn_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic hready_in,
	input wire logic [31:0] hwdata_in,
	input wire logic [6:0] out_clk_edge_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	output logic aux_lock_to_main_sel_out,
	output logic aux_apll_up_out,
	output logic [18:0] main_apll_khz_out,
	output logic [18:0] second_main_apll_khz_out,
	output logic [18:0] aux_apll_khz_out,
	output logic [18:0] synth_one_khz_out,
	output logic [18:0] synth_two_khz_out,
	output logic [6:0] out_en_out,
	output logic [27:0] out_src_out,
	output logic [48:0] out_div_out
);
	import ocfs_pkg::*;

	logic [7:0] main_pll_ctrl_one_reg, main_pll_ctrl_one_next;
	logic [3:0] aux_pll_ctrl_one_reg, aux_pll_ctrl_one_next;
	logic [2:0] master_ctrl_six_reg, master_ctrl_six_next;
	logic [3:0] master_ctrl_seven_reg, master_ctrl_seven_next;
	logic [3:0] out_freq_sel_field_reg [`OCFS_NOUT];
	logic [3:0] out_freq_sel_field_next [`OCFS_NOUT];
	logic [6:0] out_ctrl_five_reg, out_ctrl_five_next;
	logic wr_pend_reg, wr_pend_next;
	logic [3:0] wr_idx_reg, wr_idx_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [18:0] main_khz_reg, aux_khz_reg, syn1_khz_reg, syn2_khz_reg;
	logic [18:0] main_khz_w, aux_khz_w, syn1_khz_w, syn2_khz_w;
	logic aux_up_reg, aux_up_w, lock_reg;
	logic take_w, take_r;
	ocfs_src_t slot_src [`OCFS_NOUT];

	function automatic logic [3:0] reg_index(input logic [31:0] addr);
		unique case (addr)
			`OCFS_OFF_MAIN_CTRL: reg_index = `OCFS_IDX_MAIN;
			`OCFS_OFF_AUX_CTRL: reg_index = `OCFS_IDX_AUX;
			`OCFS_OFF_MCTRL_SIX: reg_index = `OCFS_IDX_SIX;
			`OCFS_OFF_MCTRL_SEVEN: reg_index = `OCFS_IDX_SEVEN;
			`OCFS_OFF_OUT_ONE: reg_index = `OCFS_IDX_OUT1;
			`OCFS_OFF_OUT_TWO: reg_index = `OCFS_IDX_OUT2;
			`OCFS_OFF_OUT_THREE: reg_index = `OCFS_IDX_OUT3;
			`OCFS_OFF_OUT_FOUR: reg_index = `OCFS_IDX_OUT4;
			`OCFS_OFF_OUT_FIVE: reg_index = `OCFS_IDX_OUT5;
			`OCFS_OFF_STATUS: reg_index = `OCFS_IDX_STAT;
			default: reg_index = `OCFS_IDX_NONE;
		endcase
	endfunction : reg_index

	assign take_w = hsel_in && hready_in && htrans_in[`OCFS_HTRANS_ACT] && hwrite_in;
	assign take_r = hsel_in && hready_in && htrans_in[`OCFS_HTRANS_ACT] && !hwrite_in;

	// Register file: write in data phase, read data from post-write values
	always_comb begin
		main_pll_ctrl_one_next = main_pll_ctrl_one_reg;
		aux_pll_ctrl_one_next = aux_pll_ctrl_one_reg;
		master_ctrl_six_next = master_ctrl_six_reg;
		master_ctrl_seven_next = master_ctrl_seven_reg;
		out_freq_sel_field_next = out_freq_sel_field_reg;
		out_ctrl_five_next = out_ctrl_five_reg;
		wr_pend_next = take_w;
		wr_idx_next = reg_index(haddr_in);
		if (wr_pend_reg) begin
			unique case (wr_idx_reg)
				`OCFS_IDX_MAIN: main_pll_ctrl_one_next = hwdata_in[7:0];
				`OCFS_IDX_AUX: aux_pll_ctrl_one_next = hwdata_in[`OCFS_LO_NIB];
				`OCFS_IDX_SIX: master_ctrl_six_next = hwdata_in[2:0];
				`OCFS_IDX_SEVEN: master_ctrl_seven_next = hwdata_in[3:0];
				`OCFS_IDX_OUT1: begin
					out_freq_sel_field_next[0] = hwdata_in[`OCFS_LO_NIB];
					out_freq_sel_field_next[1] = hwdata_in[`OCFS_HI_NIB];
				end
				`OCFS_IDX_OUT2: begin
					out_freq_sel_field_next[2] = hwdata_in[`OCFS_LO_NIB];
					out_freq_sel_field_next[3] = hwdata_in[`OCFS_HI_NIB];
				end
				`OCFS_IDX_OUT3: begin
					out_freq_sel_field_next[4] = hwdata_in[`OCFS_LO_NIB];
					out_freq_sel_field_next[5] = hwdata_in[`OCFS_HI_NIB];
				end
				`OCFS_IDX_OUT4: out_freq_sel_field_next[6] = hwdata_in[`OCFS_LO_NIB];
				`OCFS_IDX_OUT5: out_ctrl_five_next = hwdata_in[6:0];
				default: main_pll_ctrl_one_next = main_pll_ctrl_one_reg;
			endcase
		end
		rdata_next = rdata_reg;
		if (take_r) begin
			rdata_next = 32'h00000000;
			unique case (reg_index(haddr_in))
				`OCFS_IDX_MAIN: rdata_next[7:0] = main_pll_ctrl_one_next;
				`OCFS_IDX_AUX: rdata_next[3:0] = aux_pll_ctrl_one_next;
				`OCFS_IDX_SIX: rdata_next[2:0] = master_ctrl_six_next;
				`OCFS_IDX_SEVEN: rdata_next[3:0] = master_ctrl_seven_next;
				`OCFS_IDX_OUT1: rdata_next[7:0] = {out_freq_sel_field_next[1],
					out_freq_sel_field_next[0]};
				`OCFS_IDX_OUT2: rdata_next[7:0] = {out_freq_sel_field_next[3],
					out_freq_sel_field_next[2]};
				`OCFS_IDX_OUT3: rdata_next[7:0] = {out_freq_sel_field_next[5],
					out_freq_sel_field_next[4]};
				`OCFS_IDX_OUT4: rdata_next[3:0] = out_freq_sel_field_next[6];
				`OCFS_IDX_OUT5: rdata_next[6:0] = out_ctrl_five_next;
				`OCFS_IDX_STAT: begin
					rdata_next[`OCFS_ST_AUX_UP] = aux_up_reg;
					rdata_next[`OCFS_ST_LOCK] = lock_reg;
					rdata_next[`OCFS_ST_EN] = out_en_out;
				end
				default: rdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			main_pll_ctrl_one_reg <= `OCFS_RST_VAL;
			aux_pll_ctrl_one_reg <= 4'h0;
			master_ctrl_six_reg <= 3'h0;
			master_ctrl_seven_reg <= 4'h0;
			out_freq_sel_field_reg <= '{default: 4'h0};
			out_ctrl_five_reg <= 7'h00;
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= `OCFS_IDX_NONE;
			rdata_reg <= 32'h00000000;
		end else begin
			main_pll_ctrl_one_reg <= main_pll_ctrl_one_next;
			aux_pll_ctrl_one_reg <= aux_pll_ctrl_one_next;
			master_ctrl_six_reg <= master_ctrl_six_next;
			master_ctrl_seven_reg <= master_ctrl_seven_next;
			out_freq_sel_field_reg <= out_freq_sel_field_next;
			out_ctrl_five_reg <= out_ctrl_five_next;
			wr_pend_reg <= wr_pend_next;
			wr_idx_reg <= wr_idx_next;
			rdata_reg <= rdata_next;
		end
	end

	ocfs_apll_decode u_decode (
		.lock_sel_in(main_pll_ctrl_one_reg[`OCFS_LOCK_BIT]),
		.main_freq_in(main_pll_ctrl_one_reg[`OCFS_MAIN_FREQ]),
		.main_to_aux_in(main_pll_ctrl_one_reg[`OCFS_M2A_FREQ]),
		.aux_freq_in(aux_pll_ctrl_one_reg),
		.syn1_fam_in(master_ctrl_six_reg[`OCFS_S1_FAM_BIT]),
		.syn1_mult_in(master_ctrl_seven_reg[`OCFS_S1_MULT]),
		.syn2_fam_in(master_ctrl_six_reg[`OCFS_S2_FAM_BIT]),
		.syn2_alt_in(master_ctrl_six_reg[`OCFS_S2_ALT_BIT]),
		.syn2_mult_in(master_ctrl_seven_reg[`OCFS_S2_MULT]),
		.main_khz_out(main_khz_w),
		.aux_khz_out(aux_khz_w),
		.syn1_khz_out(syn1_khz_w),
		.syn2_khz_out(syn2_khz_w),
		.aux_up_out(aux_up_w)
	);

	// Decoded frequencies and aux power state
	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			main_khz_reg <= `OCFS_K311040;
			aux_khz_reg <= `OCFS_K_NONE;
			syn1_khz_reg <= `OCFS_K_E1;
			syn2_khz_reg <= `OCFS_K_E1;
			aux_up_reg <= 1'b0;
			lock_reg <= 1'b0;
		end else begin
			main_khz_reg <= main_khz_w;
			aux_khz_reg <= aux_khz_w;
			syn1_khz_reg <= syn1_khz_w;
			syn2_khz_reg <= syn2_khz_w;
			aux_up_reg <= aux_up_w;
			lock_reg <= main_pll_ctrl_one_reg[`OCFS_LOCK_BIT];
		end
	end

	for (genvar g = 0; g < `OCFS_NOUT; g++) begin : g_slot
		ocfs_out_slot #(.IDX(g)) u_slot (
			.core_clk_in(core_clk_in),
			.rstn_in(rstn_in),
			.sel_in(out_freq_sel_field_reg[g]),
			.alt_in(out_ctrl_five_reg[g]),
			.edge_in(out_clk_edge_in[g]),
			.aux_up_in(aux_up_reg),
			.en_out(out_en_out[g]),
			.src_out(slot_src[g]),
			.div_out(out_div_out[g*7 +: 7])
		);
		assign out_src_out[g*4 +: 4] = slot_src[g];
	end

	assign hrdata_out = rdata_reg;
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
	assign aux_lock_to_main_sel_out = lock_reg;
	assign aux_apll_up_out = aux_up_reg;
	assign main_apll_khz_out = main_khz_reg;
	assign second_main_apll_khz_out = `OCFS_K312500;
	assign aux_apll_khz_out = aux_khz_reg;
	assign synth_one_khz_out = syn1_khz_reg;
	assign synth_two_khz_out = syn2_khz_reg;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	a_lock_follows_bit: assert property (
		main_pll_ctrl_one_reg[`OCFS_LOCK_BIT] |=> aux_lock_to_main_sel_out && aux_apll_up_out)
		else $error("lock bit not reflected");
	a_main_freq_map: assert property (
		main_pll_ctrl_one_reg[`OCFS_MAIN_FREQ] == 3'h3 |=> main_apll_khz_out == `OCFS_K131072)
		else $error("main APLL code 3 wrong");
	a_synth_one_ds1: assert property (
		master_ctrl_six_reg[`OCFS_S1_FAM_BIT] && master_ctrl_seven_reg[`OCFS_S1_MULT] == 2'h2
		|=> synth_one_khz_out == 19'h01820)
		else $error("synth one DS1 x4 wrong");
	a_synth_two_alt: assert property (
		master_ctrl_six_reg[`OCFS_S2_ALT_BIT] && master_ctrl_six_reg[`OCFS_S2_FAM_BIT] &&
		master_ctrl_seven_reg[`OCFS_S2_MULT] == 2'h1 |=> synth_two_khz_out == `OCFS_K38880)
		else $error("synth two alternate rate wrong");
	a_second_fixed: assert property (
		second_main_apll_khz_out == `OCFS_K312500)
		else $error("second main APLL not fixed");
	a_aux_indep_map: assert property (
		!main_pll_ctrl_one_reg[`OCFS_LOCK_BIT] && aux_pll_ctrl_one_reg == 4'h6
		|=> aux_apll_khz_out == `OCFS_K274944)
		else $error("aux independent code 6 wrong");
	a_aux_power_down: assert property (
		!aux_apll_up_out ##1 slot_src[0] == OCFS_SRC_AUX |-> !out_en_out[0])
		else $error("aux output alive while powered down");
	a_field_write: assert property (
		wr_pend_reg && wr_idx_reg == `OCFS_IDX_OUT1 |=> out_freq_sel_field_reg[0] ==
		$past(hwdata_in[`OCFS_LO_NIB]) && out_freq_sel_field_reg[1] == $past(hwdata_in[7:4]))
		else $error("output field write lost");
	a_out_code_off: assert property (
		out_freq_sel_field_reg[0] == 4'h0 && out_clk_edge_in[0] |=> !out_en_out[0])
		else $error("code zero did not disable output");
	a_out_boundary: assert property (
		out_en_out[0] && !out_clk_edge_in[0] |=> $stable(slot_src[0]) &&
		$stable(out_div_out[6:0]))
		else $error("output changed between boundaries");
	a_div_main16: assert property (
		!out_ctrl_five_reg[0] && out_freq_sel_field_reg[0] == 4'h6 &&
		(out_clk_edge_in[0] || !out_en_out[0])
		|=> slot_src[0] == OCFS_SRC_MAIN && out_div_out[6:0] == 7'h10)
		else $error("divide by 16 not selected");
	a_read_status: assert property (
		take_r && reg_index(haddr_in) == `OCFS_IDX_STAT |=> hrdata_out[`OCFS_ST_EN] ==
		$past(out_en_out))
		else $error("status read mismatch");

	c_lock_rise: cover property ($rose(aux_lock_to_main_sel_out));
	c_aux_down: cover property ($fell(aux_apll_up_out));
	c_out_aux_on: cover property (out_en_out[0] && slot_src[0] == OCFS_SRC_AUX);
	c_second_sel: cover property (out_en_out[6] && slot_src[6] == OCFS_SRC_SECOND);
endmodule : ocfs_top

/* File: bench/ocfs_tb.sv */
// Self-checking bench for the output clock frequency select block.
// Assumes a zero-wait AHB-Lite slave; the bench drives every port but hready_in, looped back from hreadyout_out, and hsize_in, tied to 3'h2.
`timescale 1ns/1ps
`include "ocfs_defines.svh"
module ocfs_tb;
	import ocfs_pkg::*;
	logic core_clk_in;
	logic rstn_in;
	logic hsel_in;
	logic hwrite_in;
	logic [1:0] htrans_in;
	logic [31:0] haddr_in;
	logic [31:0] hwdata_in;
	logic [31:0] hrdata_out;
	logic [31:0] rd_val;
	logic [6:0] out_clk_edge_in;
	logic [6:0] out_en_out;
	logic hreadyout_out;
	logic hresp_out;
	logic lock_out;
	logic aux_up_out;
	logic [18:0] main_khz;
	logic [18:0] second_khz;
	logic [18:0] aux_khz;
	logic [18:0] syn1_khz;
	logic [18:0] syn2_khz;
	logic [27:0] out_src_out;
	logic [48:0] out_div_out;
	logic [2:0] c;
	logic [18:0] mk [8] = '{`OCFS_K311040, `OCFS_K311040, `OCFS_K98304, `OCFS_K131072,
		`OCFS_K148224, `OCFS_K98816, `OCFS_K100992, `OCFS_K250000};
	logic [18:0] ak [16] = '{`OCFS_K_NONE, `OCFS_K311040, `OCFS_K98304, `OCFS_K131072,
		`OCFS_K148224, `OCFS_K98816, `OCFS_K274944, `OCFS_K178944, `OCFS_K100992,
		`OCFS_K250000, `OCFS_K122880, `OCFS_K160000, `OCFS_K104000, `OCFS_K_NONE,
		`OCFS_K_NONE, `OCFS_K_NONE};
	logic [18:0] mta [8] = '{`OCFS_K98304, `OCFS_K250000, `OCFS_K131072, `OCFS_K_NONE,
		`OCFS_K148224, `OCFS_K_NONE, `OCFS_K98816, `OCFS_K100992};
	logic [31:0] q_exp [$];
	logic [3:0] q_sel [$];
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;

	ocfs_top ocfs_top_i (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .hsel_in(hsel_in),
		.haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
		.hready_in(hreadyout_out), .hwdata_in(hwdata_in), .out_clk_edge_in(out_clk_edge_in),
		.hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
		.aux_lock_to_main_sel_out(lock_out), .aux_apll_up_out(aux_up_out),
		.main_apll_khz_out(main_khz), .second_main_apll_khz_out(second_khz),
		.aux_apll_khz_out(aux_khz), .synth_one_khz_out(syn1_khz),
		.synth_two_khz_out(syn2_khz), .out_en_out(out_en_out), .out_src_out(out_src_out),
		.out_div_out(out_div_out));

	initial begin
		core_clk_in = 1'b0;
		forever #25 core_clk_in = ~core_clk_in;
	end

	function automatic logic [31:0] obs(input logic [3:0] s);
		case (s)
			4'h0: obs = {13'h0, main_khz};
			4'h1: obs = {13'h0, aux_khz};
			4'h2: obs = {13'h0, syn1_khz};
			4'h3: obs = {13'h0, syn2_khz};
			4'h4: obs = {30'h0, lock_out, aux_up_out};
			4'h6: obs = {20'h0, out_en_out[0], out_src_out[3:0], out_div_out[6:0]};
			4'h7: obs = {13'h0, second_khz};
			4'h8: obs = {20'h0, out_en_out[6], out_src_out[27:24], out_div_out[48:42]};
			4'h9: obs = {31'h0, out_en_out[6]};
			4'hA: obs = {hreadyout_out, hresp_out, 2'h0, out_src_out};
			4'hB: obs = out_div_out[38:7];
			default: obs = rd_val;
		endcase
	endfunction : obs

	function automatic logic [18:0] syn_exp(input logic [3:0] k);
		logic [18:0] f;
		f = (k[2] ? `OCFS_K_DS1 : `OCFS_K_E1) << k[1:0];
		if (k[3]) begin
			case ({k[1:0], k[2]})
				3'h0: f = `OCFS_K6312;
				3'h4: f = `OCFS_K10000;
				3'h1: f = `OCFS_K19440;
				3'h3: f = `OCFS_K38880;
				default: f = `OCFS_K_NONE;
			endcase
		end
		return f;
	endfunction : syn_exp

	task automatic note(input logic [3:0] s, input logic [31:0] e);
		q_sel.push_back(s);
		q_exp.push_back(e);
	endtask : note

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		haddr_in <= a;
		hwrite_in <= w;
		htrans_in <= 2'h2;
		hsel_in <= 1'b1;
		@(posedge core_clk_in);
		while (hreadyout_out !== 1'b1) @(posedge core_clk_in);
		htrans_in <= 2'h0;
		hwdata_in <= d;
		@(posedge core_clk_in);
		while (hreadyout_out !== 1'b1) @(posedge core_clk_in);
		rd_val = hrdata_out;
	endtask : bus

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask : wr

	task automatic wrs(input logic [31:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
		@(posedge core_clk_in);
	endtask : wrs

	task automatic pulse(input logic [6:0] m);
		out_clk_edge_in <= m;
		@(posedge core_clk_in);
		out_clk_edge_in <= 7'h00;
	endtask : pulse

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : complete_run

	// Monitor: compare every queued expectation against the live outputs, or against rd_val for selector 5 (bus reads)
	always @(negedge core_clk_in) begin
		while (q_sel.size() > 0) begin
			check(obs(q_sel[0]), q_exp[0]);
			void'(q_sel.pop_front());
			void'(q_exp.pop_front());
		end
	end

	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			complete_run();
		end
	end

	initial begin
		rstn_in = 1'b0;
		hsel_in = 1'b0;
		haddr_in = 32'h0;
		htrans_in = 2'h0;
		hwrite_in = 1'b0;
		hwdata_in = 32'h0;
		out_clk_edge_in = 7'h00;
		rd_val = 32'h0;
		repeat (8) @(posedge core_clk_in);
		rstn_in <= 1'b1;
		@(posedge core_clk_in);
		void'($urandom(32'h9C85));
		note(4'h0, {13'h0, `OCFS_K311040});
		note(4'h1, 32'h0);
		note(4'h2, {13'h0, `OCFS_K_E1});
		note(4'h7, {13'h0, `OCFS_K312500});
		note(4'h6, {20'h0, 1'b0, 4'h0, 7'h01});
		for (int i = 0; i < 16; i++) begin
			c = (i < 8) ? 3'(i) : 3'($urandom_range(7, 0));
			wrs(`OCFS_OFF_MAIN_CTRL, {29'h0, c});
			note(4'h0, {13'h0, mk[c]});
		end
		for (int k = 0; k < 16; k++) begin
			wr(`OCFS_OFF_MCTRL_SIX, {29'h0, k[3], k[2], k[2]});
			wrs(`OCFS_OFF_MCTRL_SEVEN, {28'h0, k[1:0], k[1:0]});
			note(4'h2, {13'h0, syn_exp({1'b0, k[2:0]})});
			note(4'h3, {13'h0, syn_exp(4'(k))});
		end
		for (int a = 0; a < 16; a++) begin
			wrs(`OCFS_OFF_AUX_CTRL, 32'(a));
			note(4'h1, {13'h0, ak[a]});
			note(4'h4, {31'h0, a != 0});
		end
		wrs(`OCFS_OFF_AUX_CTRL, 32'h1);
		note(4'h1, {13'h0, `OCFS_K311040});
		note(4'h4, 32'h1);
		wrs(`OCFS_OFF_AUX_CTRL, 32'h0);
		note(4'h1, 32'h0);
		note(4'h4, 32'h0);
		for (int m = 0; m < 8; m++) begin
			wrs(`OCFS_OFF_MAIN_CTRL, {24'h0, 1'b1, 3'(m), 4'h0});
			note(4'h1, {13'h0, mta[m]});
			note(4'h4, 32'h3);
		end
		wrs(`OCFS_OFF_MAIN_CTRL, 32'h91);
		note(4'h1, {13'h0, `OCFS_K250000});
		note(4'h4, 32'h3);
		bus(`OCFS_OFF_STATUS, 1'b0, 32'h0);
		note(4'h5, 32'h3);
		wr(32'h40, 32'hFF);
		bus(32'h40, 1'b0, 32'h0);
		note(4'h5, 32'h0);
		wrs(`OCFS_OFF_OUT_ONE, 32'h6);
		note(4'h6, {20'h0, 1'b1, 4'h5, 7'h10});
		wr(`OCFS_OFF_OUT_ONE, 32'hA);
		repeat (3) @(posedge core_clk_in);
		note(4'h6, {20'h0, 1'b1, 4'h5, 7'h10});
		pulse(7'h01);
		note(4'h6, {20'h0, 1'b1, 4'h5, 7'h04});
		wr(`OCFS_OFF_OUT_ONE, 32'h0);
		pulse(7'h01);
		note(4'h6, {20'h0, 1'b0, 4'h0, 7'h01});
		wr(`OCFS_OFF_OUT_FIVE, 32'h41);
		wrs(`OCFS_OFF_OUT_ONE, 32'h6);
		note(4'h6, {20'h0, 1'b1, 4'h6, 7'h05});
		wrs(`OCFS_OFF_OUT_FOUR, 32'h2);
		note(4'h8, {20'h0, 1'b1, 4'h7, 7'h02});
		wrs(`OCFS_OFF_MAIN_CTRL, 32'h0);
		pulse(7'h40);
		note(4'h4, 32'h0);
		note(4'h9, 32'h0);
		rstn_in <= 1'b0;
		@(posedge core_clk_in);
		rstn_in <= 1'b1;
		@(posedge core_clk_in);
		note(4'h6, {20'h0, 1'b0, 4'h0, 7'h01});
		note(4'h0, {13'h0, `OCFS_K311040});
		note(4'hA, 32'h80000000);
		note(4'hB, 32'h10204081);
		wrs(`OCFS_OFF_OUT_ONE, 32'hD);
		note(4'h6, {20'h0, 1'b0, 4'h7, 7'h10});
		wrs(`OCFS_OFF_AUX_CTRL, 32'h1);
		@(posedge core_clk_in);
		note(4'h6, {20'h0, 1'b1, 4'h7, 7'h10});
		@(negedge core_clk_in);
		@(posedge core_clk_in);
		complete_run();
	end
endmodule : ocfs_tb
